// ==== logic/rpr_map.vh ====
`ifndef RPR_MAP_VH
`define RPR_MAP_VH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define RPR_ADDR_BUFFER        7'h00
`define RPR_ADDR_OPMODE        7'h01
`define RPR_ADDR_CARRIER_HIGH  7'h06
`define RPR_ADDR_PAGE_FIRST    7'h0d
`define RPR_ADDR_PAGE_LAST     7'h3f
`define RPR_ADDR_BAND_FIRST    7'h61
`define RPR_ADDR_BAND_LAST     7'h73
`define RPR_ADDR_GAIN_FLOOR    7'h61
`define RPR_ADDR_GAIN_THR_A    7'h62
`define RPR_ADDR_GAIN_THR_B    7'h63
`define RPR_ADDR_GAIN_THR_C    7'h64
`define RPR_ADDR_SYNTH_LOOP    7'h70

// ----------------------------------------------------------------------------
// operating mode control fields
// ----------------------------------------------------------------------------
`define RPR_OPM_MODEM_BIT      7
`define RPR_OPM_SHARED_BIT     6
`define RPR_OPM_BAND_BIT       3
`define RPR_OPM_STATE_MSB      2
`define RPR_RST_MODEM          1'b0
`define RPR_RST_SHARED         1'b0
`define RPR_RST_BAND           1'b1
`define RPR_RST_STATE          3'h1
`define RPR_RST_CARRIER_HIGH   8'h6c

// ----------------------------------------------------------------------------
// device state codes
// ----------------------------------------------------------------------------
`define RPR_ST_SLEEP           3'h0
`define RPR_ST_STANDBY         3'h1
`define RPR_ST_TX_SYNTH        3'h2
`define RPR_ST_TRANSMIT        3'h3
`define RPR_ST_RX_SYNTH        3'h4
`define RPR_ST_RX_CONT         3'h5
`define RPR_ST_RX_SINGLE       3'h6
`define RPR_ST_ACTIVITY        3'h7

// ----------------------------------------------------------------------------
// band bank reset values
// ----------------------------------------------------------------------------
`define RPR_LB_FLOOR           6'h19
`define RPR_LB_THR_A           5'h0c
`define RPR_LB_THR_B           8'h4b
`define RPR_LB_THR_C           8'hcc
`define RPR_LB_SYNTH           8'hd0
`define RPR_HB_FLOOR           6'h1c
`define RPR_HB_THR_A           5'h0e
`define RPR_HB_THR_B           8'h5b
`define RPR_HB_THR_C           8'hcc
`define RPR_HB_SYNTH           8'hd0

// ----------------------------------------------------------------------------
// synthesizer loop bandwidth in kHz
// ----------------------------------------------------------------------------
`define RPR_BW_CODE0_KHZ       9'h04b
`define RPR_BW_CODE1_KHZ       9'h096
`define RPR_BW_CODE2_KHZ       9'h0e1
`define RPR_BW_CODE3_KHZ       9'h12c

// ----------------------------------------------------------------------------
// data buffer geometry
// ----------------------------------------------------------------------------
`define RPR_BUF_AW             4
`define RPR_BUF_DEPTH          5'h10

`endif

// ==== logic/rpr_mem.v ====
`default_nettype none

// ----------------------------------------------------------------------------
// single port write, registered read byte memory
// ----------------------------------------------------------------------------
module rpr_mem #(
    parameter AW = 4
) (
    input  wire          clock_i,
    input  wire          resetn_i,
    input  wire          we_i,
    input  wire [AW-1:0] waddr_i,
    input  wire [7:0]    wdata_i,
    input  wire [AW-1:0] raddr_i,
    output reg  [7:0]    rdata_o
);

    reg [7:0] store_reg [0:(1<<AW)-1];

    // storage array, no reset
    always @(posedge clock_i) begin
        if (we_i) begin
            store_reg[waddr_i] <= wdata_i;
        end
    end

    // read data always from a flop
    always @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_o <= 8'h00;
        end else begin
            rdata_o <= store_reg[raddr_i];
        end
    end

endmodule // rpr_mem

`default_nettype wire

// ==== logic/rpr_band_bank.v ====
`default_nettype none
`include "rpr_map.vh"

// ----------------------------------------------------------------------------
// one copy of the band specific registers
// ----------------------------------------------------------------------------
module rpr_band_bank #(
    parameter [5:0] RST_FLOOR = 6'h00,
    parameter [4:0] RST_THR_A = 5'h00,
    parameter [7:0] RST_THR_B = 8'h00,
    parameter [7:0] RST_THR_C = 8'h00,
    parameter [7:0] RST_SYNTH = 8'h00
) (
    input  wire       clock_i,
    input  wire       resetn_i,
    input  wire       wr_i,
    input  wire [6:0] addr_i,
    input  wire [7:0] wdata_i,
    output reg  [7:0] rdata_o,
    output reg  [5:0] floor_o,
    output reg  [4:0] thr_a_o,
    output reg  [7:0] thr_b_o,
    output reg  [7:0] thr_c_o,
    output reg  [7:0] synth_o
);

    // field storage, held while the other bank is selected
    always @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            floor_o <= RST_FLOOR;
            thr_a_o <= RST_THR_A;
            thr_b_o <= RST_THR_B;
            thr_c_o <= RST_THR_C;
            synth_o <= RST_SYNTH;
        end else if (wr_i) begin
            case (addr_i)
                `RPR_ADDR_GAIN_FLOOR: floor_o <= wdata_i[5:0]; // upper bits ignored
                `RPR_ADDR_GAIN_THR_A: thr_a_o <= wdata_i[4:0];
                `RPR_ADDR_GAIN_THR_B: thr_b_o <= wdata_i;
                `RPR_ADDR_GAIN_THR_C: thr_c_o <= wdata_i;
                `RPR_ADDR_SYNTH_LOOP: synth_o <= wdata_i;
                default: ;
            endcase
        end
    end

    // read mux, unused bits as zero
    always @* begin
        case (addr_i)
            `RPR_ADDR_GAIN_FLOOR: rdata_o = {2'h0, floor_o};
            `RPR_ADDR_GAIN_THR_A: rdata_o = {3'h0, thr_a_o};
            `RPR_ADDR_GAIN_THR_B: rdata_o = thr_b_o;
            `RPR_ADDR_GAIN_THR_C: rdata_o = thr_c_o;
            `RPR_ADDR_SYNTH_LOOP: rdata_o = synth_o;
            default:              rdata_o = 8'h00;
        endcase
    end

endmodule // rpr_band_bank

`default_nettype wire

// ==== logic/rpr_register_map.v ====
`default_nettype none
`include "rpr_map.vh"

module rpr_register_map (
    input  wire       clock_i,
    input  wire       resetn_i,
    input  wire [6:0] addr_i,
    input  wire [7:0] wdata_i,
    input  wire       wr_i,
    input  wire       rd_i,
    output reg  [7:0] rdata_o,
    output reg  [7:0] state_onehot_o,
    output reg  [2:0] state_code_o,
    output reg        state_start_o,
    output reg        modem_select_o,
    output reg        shared_page_select_o,
    output reg        band_bank_select_o,
    output reg  [7:0] carrier_high_o,
    output reg  [5:0] gain_floor_level_o,
    output reg  [4:0] gain_threshold_first_o,
    output reg  [3:0] gain_threshold_second_o,
    output reg  [3:0] gain_threshold_third_o,
    output reg  [3:0] gain_threshold_fourth_o,
    output reg  [3:0] gain_threshold_fifth_o,
    output reg  [8:0] synth_loop_khz_o,
    output reg  [4:0] buffer_level_o
);

    // read source selectors
    localparam [2:0] SRC_LOCAL = 3'b001;
    localparam [2:0] SRC_PAGE  = 3'b010;
    localparam [2:0] SRC_BUF   = 3'b100;

    // low band threshold resets; named so the nibbles can be selected
    // without silently narrowing an eight bit constant
    localparam [7:0] LB_THR_B  = `RPR_LB_THR_B;
    localparam [7:0] LB_THR_C  = `RPR_LB_THR_C;

    // ------------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------------
    wire       in_sleep   = (state_code_o == `RPR_ST_SLEEP);
    wire       hit_buf    = (addr_i == `RPR_ADDR_BUFFER);
    wire       hit_opm    = (addr_i == `RPR_ADDR_OPMODE);
    wire       hit_car    = (addr_i == `RPR_ADDR_CARRIER_HIGH);
    wire       hit_page   = (addr_i >= `RPR_ADDR_PAGE_FIRST) &&
                            (addr_i <= `RPR_ADDR_PAGE_LAST);
    wire       hit_band   = (addr_i >= `RPR_ADDR_BAND_FIRST) &&
                            (addr_i <= `RPR_ADDR_BAND_LAST);
    // long range page only in long range mode with shared bit clear
    wire       page_lr    = modem_select_o & ~shared_page_select_o;
    wire [6:0] page_addr  = {page_lr, addr_i[5:0]};

    reg  [2:0] src_reg;
    reg  [7:0] local_reg;
    reg  [3:0] wptr_reg;
    reg  [3:0] rptr_reg;

    // buffer access is closed while asleep
    wire       buf_open   = ~in_sleep;
    wire       buf_push   = wr_i & hit_buf & buf_open & (buffer_level_o != `RPR_BUF_DEPTH);
    wire       buf_pop    = rd_i & hit_buf & buf_open & (buffer_level_o != 5'h00);

    // registered read data of the two memories
    wire [7:0] buf_rdata;
    wire [7:0] page_rdata;

    // ------------------------------------------------------------------------
    // operating mode control
    // ------------------------------------------------------------------------
    // modem bit follows a write only while the current state is sleep
    always @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            modem_select_o       <= `RPR_RST_MODEM;
            shared_page_select_o <= `RPR_RST_SHARED;
            band_bank_select_o   <= `RPR_RST_BAND;
            state_code_o         <= `RPR_RST_STATE;
            state_start_o        <= 1'b0;
        end else begin
            state_start_o <= wr_i & hit_opm;
            if (wr_i && hit_opm) begin
                if (in_sleep) begin
                    modem_select_o <= wdata_i[`RPR_OPM_MODEM_BIT];
                end
                shared_page_select_o <= wdata_i[`RPR_OPM_SHARED_BIT];
                band_bank_select_o   <= wdata_i[`RPR_OPM_BAND_BIT];
                state_code_o         <= wdata_i[`RPR_OPM_STATE_MSB:0];
            end
        end
    end

    // one-hot device state, bit n for code n
    always @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_onehot_o <= 8'h02;
        end else begin
            case (state_code_o)
                `RPR_ST_SLEEP:    state_onehot_o <= 8'h01;
                `RPR_ST_STANDBY:  state_onehot_o <= 8'h02;
                `RPR_ST_TX_SYNTH: state_onehot_o <= 8'h04;
                `RPR_ST_TRANSMIT: state_onehot_o <= 8'h08;
                `RPR_ST_RX_SYNTH: state_onehot_o <= 8'h10;
                `RPR_ST_RX_CONT:  state_onehot_o <= 8'h20;
                `RPR_ST_RX_SINGLE: state_onehot_o <= 8'h40;
                `RPR_ST_ACTIVITY: state_onehot_o <= 8'h80;
                default:          state_onehot_o <= 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // carrier frequency high byte
    // ------------------------------------------------------------------------
    always @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            carrier_high_o <= `RPR_RST_CARRIER_HIGH;
        end else if (wr_i && hit_car) begin
            carrier_high_o <= wdata_i;
        end
    end

    // ------------------------------------------------------------------------
    // data buffer port
    // ------------------------------------------------------------------------
    // pointers and level wiped while asleep, so old bytes never reappear
    always @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wptr_reg       <= 4'h0;
            rptr_reg       <= 4'h0;
            buffer_level_o <= 5'h00;
        end else if (in_sleep) begin
            wptr_reg       <= 4'h0;
            rptr_reg       <= 4'h0;
            buffer_level_o <= 5'h00;
        end else begin
            if (buf_push) begin
                wptr_reg <= wptr_reg + 4'h1;
            end
            if (buf_pop) begin
                rptr_reg <= rptr_reg + 4'h1;
            end
            if (buf_push && !buf_pop) begin
                buffer_level_o <= buffer_level_o + 5'h01;
            end else if (buf_pop && !buf_push) begin
                buffer_level_o <= buffer_level_o - 5'h01;
            end
        end
    end

    rpr_mem #(
        .AW      (`RPR_BUF_AW)
    ) u_buffer (
        .clock_i  (clock_i),
        .resetn_i (resetn_i),
        .we_i     (buf_push),
        .waddr_i  (wptr_reg),
        .wdata_i  (wdata_i),
        .raddr_i  (rptr_reg),
        .rdata_o  (buf_rdata)
    );

    // ------------------------------------------------------------------------
    // shared address page storage
    // ------------------------------------------------------------------------

    // fsk copy at index 0..63, long range copy at 64..127
    rpr_mem #(
        .AW      (7)
    ) u_pages (
        .clock_i  (clock_i),
        .resetn_i (resetn_i),
        .we_i     (wr_i & hit_page),
        .waddr_i  (page_addr),
        .wdata_i  (wdata_i),
        .raddr_i  (page_addr),
        .rdata_o  (page_rdata)
    );

    // ------------------------------------------------------------------------
    // band specific banks
    // ------------------------------------------------------------------------
    wire [7:0] lb_rdata;
    wire [7:0] hb_rdata;
    wire [5:0] lb_floor;
    wire [5:0] hb_floor;
    wire [4:0] lb_thr_a;
    wire [4:0] hb_thr_a;
    wire [7:0] lb_thr_b;
    wire [7:0] hb_thr_b;
    wire [7:0] lb_thr_c;
    wire [7:0] hb_thr_c;
    wire [7:0] lb_synth;
    wire [7:0] hb_synth;

    // only the selected copy takes a write; the other keeps its value
    rpr_band_bank #(
        .RST_FLOOR (`RPR_LB_FLOOR),
        .RST_THR_A (`RPR_LB_THR_A),
        .RST_THR_B (`RPR_LB_THR_B),
        .RST_THR_C (`RPR_LB_THR_C),
        .RST_SYNTH (`RPR_LB_SYNTH)
    ) u_low_band (
        .clock_i  (clock_i),
        .resetn_i (resetn_i),
        .wr_i     (wr_i & hit_band & band_bank_select_o),
        .addr_i   (addr_i),
        .wdata_i  (wdata_i),
        .rdata_o  (lb_rdata),
        .floor_o  (lb_floor),
        .thr_a_o  (lb_thr_a),
        .thr_b_o  (lb_thr_b),
        .thr_c_o  (lb_thr_c),
        .synth_o  (lb_synth)
    );

    rpr_band_bank #(
        .RST_FLOOR (`RPR_HB_FLOOR),
        .RST_THR_A (`RPR_HB_THR_A),
        .RST_THR_B (`RPR_HB_THR_B),
        .RST_THR_C (`RPR_HB_THR_C),
        .RST_SYNTH (`RPR_HB_SYNTH)
    ) u_high_band (
        .clock_i  (clock_i),
        .resetn_i (resetn_i),
        .wr_i     (wr_i & hit_band & ~band_bank_select_o),
        .addr_i   (addr_i),
        .wdata_i  (wdata_i),
        .rdata_o  (hb_rdata),
        .floor_o  (hb_floor),
        .thr_a_o  (hb_thr_a),
        .thr_b_o  (hb_thr_b),
        .thr_c_o  (hb_thr_c),
        .synth_o  (hb_synth)
    );

    // active band fields driven out from flops
    always @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            gain_floor_level_o      <= `RPR_LB_FLOOR;
            gain_threshold_first_o  <= `RPR_LB_THR_A;
            gain_threshold_second_o <= LB_THR_B[7:4];
            gain_threshold_third_o  <= LB_THR_B[3:0];
            gain_threshold_fourth_o <= LB_THR_C[7:4];
            gain_threshold_fifth_o  <= LB_THR_C[3:0];
        end else if (band_bank_select_o) begin
            gain_floor_level_o      <= lb_floor;
            gain_threshold_first_o  <= lb_thr_a;
            gain_threshold_second_o <= lb_thr_b[7:4];
            gain_threshold_third_o  <= lb_thr_b[3:0];
            gain_threshold_fourth_o <= lb_thr_c[7:4];
            gain_threshold_fifth_o  <= lb_thr_c[3:0];
        end else begin
            gain_floor_level_o      <= hb_floor;
            gain_threshold_first_o  <= hb_thr_a;
            gain_threshold_second_o <= hb_thr_b[7:4];
            gain_threshold_third_o  <= hb_thr_b[3:0];
            gain_threshold_fourth_o <= hb_thr_c[7:4];
            gain_threshold_fifth_o  <= hb_thr_c[3:0];
        end
    end

    // loop bandwidth code to kHz for the active band
    wire [1:0] bw_code = band_bank_select_o ? lb_synth[7:6] : hb_synth[7:6];

    always @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            synth_loop_khz_o <= `RPR_BW_CODE3_KHZ;
        end else begin
            case (bw_code)
                2'h0:    synth_loop_khz_o <= `RPR_BW_CODE0_KHZ;
                2'h1:    synth_loop_khz_o <= `RPR_BW_CODE1_KHZ;
                2'h2:    synth_loop_khz_o <= `RPR_BW_CODE2_KHZ;
                default: synth_loop_khz_o <= `RPR_BW_CODE3_KHZ;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------------
    // local read value; reserved bits and unmapped addresses give zero
    reg [7:0] local_next;

    always @* begin
        local_next = 8'h00;
        if (hit_opm) begin
            local_next = {modem_select_o, shared_page_select_o, 2'h0,
                          band_bank_select_o, state_code_o};
        end else if (hit_car) begin
            local_next = carrier_high_o;
        end else if (hit_band) begin
            local_next = band_bank_select_o ? lb_rdata : hb_rdata;
        end
    end

    // capture value or pick which flop delivers it next cycle
    always @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            src_reg   <= SRC_LOCAL;
            local_reg <= 8'h00;
        end else if (rd_i) begin
            local_reg <= local_next;
            if (buf_pop) begin
                src_reg <= SRC_BUF;
            end else if (hit_page) begin
                src_reg <= SRC_PAGE;
            end else begin
                src_reg <= SRC_LOCAL;
            end
        end else begin
            src_reg   <= SRC_LOCAL;
            local_reg <= 8'h00;
        end
    end

    // final selection among three flops
    always @* begin
        case (src_reg)
            SRC_PAGE: rdata_o = page_rdata;
            SRC_BUF:  rdata_o = buf_rdata;
            default:  rdata_o = local_reg;
        endcase
    end

endmodule // rpr_register_map

`default_nettype wire

// ==== test/rpr_map_properties.sv ====
`default_nettype none

// --------------------------------
// register map port checker
// --------------------------------
module rpr_map_checker (
    input wire logic       clock_i,
    input wire logic       resetn_i,
    input wire logic [6:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic       wr_i,
    input wire logic       rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic [7:0] state_onehot_o,
    input wire logic [2:0] state_code_o,
    input wire logic       state_start_o,
    input wire logic       modem_select_o,
    input wire logic [4:0] buffer_level_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // one clock domain, checks idle during reset
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!resetn_i);

    // mode register write and accepted buffer push
    sequence s_opmode_write;
        wr_i && addr_i == 7'h01;
    endsequence
    sequence s_buf_push;
        wr_i && addr_i == 7'h00 && state_code_o != 3'h0 && buffer_level_o < 5'h10;
    endsequence

    property p_state_write;
        s_opmode_write |=> ($past(wdata_i) & 8'h07) == {5'h00, state_code_o} && state_start_o;
    endproperty
    a_state_write: assert property (p_state_write) else $error("state not written");
    property p_start_cause;
        state_start_o |-> $past(wr_i) && $past(addr_i) == 7'h01;
    endproperty
    a_start_cause: assert property (p_start_cause) else $error("stray start pulse");
    property p_onehot;
        state_onehot_o == 8'h01 << $past(state_code_o);
    endproperty
    a_onehot: assert property (p_onehot) else $error("state decode wrong");
    property p_modem_locked;
        !$stable(modem_select_o) |->
            $past(wr_i) && $past(addr_i) == 7'h01 && $past(state_code_o) == 3'h0;
    endproperty
    a_modem_locked: assert property (p_modem_locked) else $error("modem moved");
    property p_modem_write;
        s_opmode_write ##0 state_code_o == 3'h0 |=>
            ($past(wdata_i) & 8'h80) == {modem_select_o, 7'h00};
    endproperty
    a_modem_write: assert property (p_modem_write) else $error("modem not written");
    property p_rsvd_read;
        rd_i && addr_i inside {[7'h02:7'h05]} |=> rdata_o == 8'h00;
    endproperty
    a_rsvd_read: assert property (p_rsvd_read) else $error("reserved read nonzero");
    property p_sleep_empty;
        state_code_o == 3'h0 |=> buffer_level_o == 5'h00;
    endproperty
    a_sleep_empty: assert property (p_sleep_empty) else $error("buffer kept in sleep");
    property p_buf_push;
        s_buf_push |=> buffer_level_o == $past(buffer_level_o) + 5'h01;
    endproperty
    a_buf_push: assert property (p_buf_push) else $error("push not counted");
endmodule // rpr_map_checker

bind rpr_register_map rpr_map_checker u_map_checker (
    .clock_i(clock_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .state_onehot_o(state_onehot_o),
    .state_code_o(state_code_o), .state_start_o(state_start_o),
    .modem_select_o(modem_select_o), .buffer_level_o(buffer_level_o)
);

`default_nettype wire

// ==== test/rpr_register_map_tb.sv ====
`default_nettype none

// --------------------------------
// register map testbench
// --------------------------------
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic       clock_i, resetn_i, wr_i, rd_i;
    logic [2:0] state_code_o;
    logic       band_bank_select_o, shared_page_select_o, modem_select_o;
    logic [3:0] gain_threshold_second_o, gain_threshold_third_o;
    logic [3:0] gain_threshold_fourth_o, gain_threshold_fifth_o;
    logic [4:0] gain_threshold_first_o, buffer_level_o;
    logic [5:0] gain_floor_level_o;
    logic [6:0] addr_i, a;
    logic [7:0] wdata_i, rdata_o, state_onehot_o, carrier_high_o;
    logic [8:0] synth_loop_khz_o;
    int         miscompares = 0;
    int         checks = 0;
    int         i;

    rpr_register_map DUT (
        .clock_i(clock_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .state_onehot_o(state_onehot_o),
        .state_code_o(state_code_o), .state_start_o(), .modem_select_o(modem_select_o),
        .shared_page_select_o(shared_page_select_o),
        .band_bank_select_o(band_bank_select_o), .carrier_high_o(carrier_high_o),
        .gain_floor_level_o(gain_floor_level_o),
        .gain_threshold_first_o(gain_threshold_first_o),
        .gain_threshold_second_o(gain_threshold_second_o),
        .gain_threshold_third_o(gain_threshold_third_o),
        .gain_threshold_fourth_o(gain_threshold_fourth_o),
        .gain_threshold_fifth_o(gain_threshold_fifth_o),
        .synth_loop_khz_o(synth_loop_khz_o), .buffer_level_o(buffer_level_o)
    );

    // free running clock
    initial begin
        clock_i = 1'b0;
        forever #10 clock_i = ~clock_i;
    end

    // hang guard
    initial begin
        repeat (5000) @(posedge clock_i);
        miscompares++;
        end_of_test;
    end

    // compare and count
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // bus cycles: one strobe cycle each
    task automatic wr(input logic [6:0] ad, input logic [7:0] d);
        @(posedge clock_i);
        wr_i    <= 1'b1;
        addr_i  <= ad;
        wdata_i <= d;
        @(posedge clock_i);
        wr_i    <= 1'b0;
    endtask
    task automatic rd(input logic [6:0] ad, input logic [7:0] exp);
        @(posedge clock_i);
        rd_i   <= 1'b1;
        addr_i <= ad;
        @(posedge clock_i);
        rd_i   <= 1'b0;
        #1;
        chk({1'b0, rdata_o}, {1'b0, exp});
    endtask
    task automatic settle;
        repeat (2) @(posedge clock_i);
        #1;
    endtask

    task automatic end_of_test;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // reset, then the register scenarios
    initial begin
        resetn_i = 1'b0;
        wr_i     = 1'b0;
        rd_i     = 1'b0;
        addr_i   = 7'h00;
        wdata_i  = 8'h00;
        repeat (8) @(posedge clock_i);
        resetn_i <= 1'b1;
        rd(7'h06, 8'h6c);
        rd(7'h01, 8'h09);
        for (i = 2; i < 6; i++) rd(i[6:0], 8'h00);
        chk({3'h0, gain_floor_level_o}, 9'h019);
        chk({8'h00, band_bank_select_o}, 9'h001);
        // high band copy, unused bits, retention
        wr(7'h01, 8'h01);
        settle;
        chk({3'h0, gain_floor_level_o}, 9'h01c);
        chk({gain_threshold_first_o, gain_threshold_second_o}, 9'h0e5);
        chk({1'b0, gain_threshold_third_o, gain_threshold_fourth_o}, 9'h0bc);
        chk({5'h00, gain_threshold_fifth_o}, 9'h00c);
        chk({8'h00, band_bank_select_o}, 9'h000);
        rd(7'h63, 8'h5b);
        rd(7'h64, 8'hcc);
        wr(7'h61, 8'hea);
        rd(7'h61, 8'h2a);
        wr(7'h01, 8'h09);
        rd(7'h61, 8'h19);
        wr(7'h01, 8'h01);
        rd(7'h61, 8'h2a);
        // every bandwidth code
        for (i = 0; i < 4; i++) begin
            wr(7'h70, {i[1:0], 6'h10});
            settle;
            chk(synth_loop_khz_o, 9'd75 * (i[8:0] + 9'd1));
        end
        // every state code
        for (i = 0; i < 8; i++) begin
            wr(7'h01, {5'h01, i[2:0]});
            settle;
            chk({6'h00, state_code_o}, i[8:0]);
            chk({1'b0, state_onehot_o}, 9'h001 << i);
        end
        wr(7'h01, 8'h89);
        rd(7'h01, 8'h09);
        // page routing at both ends of the shared range
        for (i = 0; i < 2; i++) begin
            a = (i == 0) ? 7'h0d : 7'h3f;
            wr(7'h01, 8'h08);
            wr(7'h01, 8'h88);
            rd(7'h01, 8'h88);
            wr(a, 8'ha5);
            wr(7'h01, 8'hc8);
            wr(a, 8'h3c);
            rd(a, 8'h3c);
            chk({7'h00, modem_select_o, shared_page_select_o}, 9'h003);
            wr(7'h01, 8'h88);
            rd(a, 8'ha5);
            wr(7'h01, 8'h48);
            rd(a, 8'h3c);
        end
        // fill past full, drain in order, sleep clears and closes
        wr(7'h01, 8'h09);
        for (i = 0; i < 17; i++) wr(7'h00, i[7:0]);
        #1;
        chk({4'h0, buffer_level_o}, 9'h010);
        for (i = 0; i < 16; i++) rd(7'h00, i[7:0]);
        rd(7'h00, 8'h00);
        wr(7'h00, 8'h77);
        wr(7'h01, 8'h08);
        settle;
        chk({4'h0, buffer_level_o}, 9'h000);
        wr(7'h00, 8'h55);
        rd(7'h00, 8'h00);
        wr(7'h01, 8'h09);
        rd(7'h00, 8'h00);
        // carrier byte holds until a second reset
        wr(7'h06, 8'h12);
        rd(7'h06, 8'h12);
        chk({1'b0, carrier_high_o}, 9'h012);
        @(posedge clock_i);
        resetn_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        resetn_i <= 1'b1;
        rd(7'h06, 8'h6c);
        end_of_test;
    end
endmodule // testbench

`default_nettype wire
